// ---- rtl/fp_regs_map.svh ----
`ifndef FP_REGS_MAP_SVH
`define FP_REGS_MAP_SVH
`define SEL_IDENT     4'h0
`define SEL_STATCTL   4'h1
`define SC_RESET      32'h00000000
`define SC_NZCV_HI    31
`define SC_NZCV_LO    28
`define SC_NAN_DEF    25
`define SC_FLUSH      24
`define SC_RND_HI     23
`define SC_RND_LO     22
`define SC_ST_HI      21
`define SC_ST_LO      20
`define SC_ITER_HI    18
`define SC_ITER_LO    16
`define SC_SUBN_TRAP  15
`define SC_TRAP_HI    12
`define SC_TRAP_LO    8
`define SC_SUBN_STK   7
`define SC_STK_HI     4
`define SC_STK_LO     0
`define ID_HW_SW      1'h0
`define ID_FORMAT     2'h0
`define ID_PRECISION  1'h0
`define NZCV_LT       4'h8
`define NZCV_EQ       4'h6
`define NZCV_GT       4'h2
`define NZCV_UN       4'h3
`define ITER_ONE      4'h1
`define STRIDE_TWO    2'h3
`endif

// ---- rtl/fp_regs_pkg.sv ----
package fp_regs_pkg;

  // Outcome of one floating-point comparison.
  typedef enum logic [1:0] {
    CMP_LT = 2'h0,
    CMP_EQ = 2'h1,
    CMP_GT = 2'h3,
    CMP_UN = 2'h2
  } cmp_e;

  // Rounding mode encodings of the status/control word.
  typedef enum logic [1:0] {
    ROUND_NEAREST  = 2'h0,
    ROUND_UP       = 2'h1,
    ROUND_DOWN     = 2'h2,
    ROUND_TRUNCATE = 2'h3
  } round_e;

  // One coprocessor register transfer from the core.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  sel;
    logic [31:0] wdata;
  } xfer_req_s;

  // Whole state of the register bank.
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        ack;
    logic        undef;
    logic [3:0]  iter;
    logic [1:0]  stride_inc;
  } bank_state_s;

endpackage : fp_regs_pkg

// ---- rtl/fp_status_and_id_regs.sv ----
`timescale 1ns/1ps
`include "fp_regs_map.svh"

module fp_status_and_id_regs
  import fp_regs_pkg::*;
#(
  parameter logic [7:0] IMPLEMENTER = 8'h5A, // Arbitrary value.
  parameter logic [3:0] ARCH_VER    = 4'h3,  // Arbitrary value.
  parameter logic [7:0] PART_NUM    = 8'h7C, // Arbitrary value.
  parameter logic [3:0] VARIANT     = 4'h2,  // Arbitrary value.
  parameter logic [3:0] REVISION    = 4'h6   // Arbitrary value.
) (
  input  wire logic       CLOCK,
  input  wire logic       RST_B,
  input  wire xfer_req_s  XFER_REQ,
  input  wire logic       CMP_VALID,
  input  wire cmp_e       CMP_RES,
  input  wire logic [5:0] EXC_SET,
  output logic [31:0]     XFER_RDATA,
  output logic            XFER_ACK,
  output logic            XFER_UNDEF,
  output logic            DEFAULT_NAN_ENABLE,
  output logic            FLUSH_ZERO_ENABLE,
  output round_e          ROUND_MODE,
  output logic [3:0]      VECTOR_ITERATIONS,
  output logic [1:0]      VECTOR_STRIDE_INC,
  output logic [5:0]      TRAP_EN
);

  bank_state_s s_r;
  bank_state_s s_nxt;
  logic [31:0] ident;

  // Flag pattern that each comparison outcome leaves in bits 31:28.
  function automatic logic [3:0] nzcv_of(input cmp_e res);
    unique case (res)
      CMP_LT: nzcv_of = `NZCV_LT;
      CMP_EQ: nzcv_of = `NZCV_EQ;
      CMP_GT: nzcv_of = `NZCV_GT;
      CMP_UN: nzcv_of = `NZCV_UN;
    endcase
  endfunction : nzcv_of

  // Gathers the six trap enables in the order of EXC_SET.
  function automatic logic [5:0] traps_of(input logic [31:0] w);
    traps_of = {w[`SC_SUBN_TRAP], w[`SC_TRAP_HI:`SC_TRAP_LO]};
  endfunction : traps_of

  // Gathers the six sticky flags in the order of EXC_SET.
  function automatic logic [5:0] sticky_of(input logic [31:0] w);
    sticky_of = {w[`SC_SUBN_STK], w[`SC_STK_HI:`SC_STK_LO]};
  endfunction : sticky_of

  // Fixed identity word; the four format bits are constants.
  assign ident = {IMPLEMENTER, `ID_HW_SW, `ID_FORMAT, `ID_PRECISION,
                  ARCH_VER, PART_NUM, VARIANT, REVISION};

  // Next state: transfer decode, comparison flags, sticky exceptions.
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ack   = XFER_REQ.valid;
    s_nxt.undef = 1'b0;
    s_nxt.rdata = 32'h00000000;
    if (XFER_REQ.valid) begin
      unique case (XFER_REQ.sel)
        `SEL_IDENT: begin
          if (XFER_REQ.write) begin
            s_nxt.undef = 1'b1; // Identity is read-only.
          end else begin
            s_nxt.rdata = ident;
          end
        end
        `SEL_STATCTL: begin
          // Any processor mode may reach this register.
          if (XFER_REQ.write) begin
            s_nxt.ctrl = XFER_REQ.wdata;
          end else begin
            s_nxt.rdata = s_r.ctrl;
          end
        end
        default: begin
          s_nxt.undef = 1'b1;
        end
      endcase
    end
    // Hardware updates win over a software write in the same cycle.
    if (CMP_VALID) begin
      s_nxt.ctrl[`SC_NZCV_HI:`SC_NZCV_LO] = nzcv_of(CMP_RES);
    end
    s_nxt.ctrl[`SC_SUBN_STK] =
      s_nxt.ctrl[`SC_SUBN_STK] | EXC_SET[5];
    s_nxt.ctrl[`SC_STK_HI:`SC_STK_LO] =
      s_nxt.ctrl[`SC_STK_HI:`SC_STK_LO] | EXC_SET[4:0];
    // Iteration count is length plus one; stride code 11 steps by two.
    s_nxt.iter =
      {1'b0, s_nxt.ctrl[`SC_ITER_HI:`SC_ITER_LO]} + `ITER_ONE;
    s_nxt.stride_inc =
      (s_nxt.ctrl[`SC_ST_HI:`SC_ST_LO] == `STRIDE_TWO) ? 2'h2 : 2'h1;
  end

  // Single state register.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= '{ctrl: `SC_RESET, rdata: 32'h00000000, ack: 1'b0,
               undef: 1'b0, iter: `ITER_ONE, stride_inc: 2'h1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs are fields of the state register.
  assign XFER_RDATA         = s_r.rdata;
  assign XFER_ACK           = s_r.ack;
  assign XFER_UNDEF         = s_r.undef;
  assign DEFAULT_NAN_ENABLE = s_r.ctrl[`SC_NAN_DEF];
  assign FLUSH_ZERO_ENABLE  = s_r.ctrl[`SC_FLUSH];
  assign ROUND_MODE         = round_e'(s_r.ctrl[`SC_RND_HI:`SC_RND_LO]);
  assign VECTOR_ITERATIONS  = s_r.iter;
  assign VECTOR_STRIDE_INC  = s_r.stride_inc;
  assign TRAP_EN            = traps_of(s_r.ctrl);

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // A software write to status/control with no hardware update beside it.
  sequence s_sc_write;
    XFER_REQ.valid && XFER_REQ.write && XFER_REQ.sel == `SEL_STATCTL
      && !CMP_VALID && EXC_SET == 6'h00;
  endsequence

  // A read of the identity register.
  sequence s_id_read;
    XFER_REQ.valid && !XFER_REQ.write && XFER_REQ.sel == `SEL_IDENT;
  endsequence

  property p_id_read;
    s_id_read |=> XFER_ACK && !XFER_UNDEF && XFER_RDATA[31:24] == IMPLEMENTER
      && XFER_RDATA[15:0] == {PART_NUM, VARIANT, REVISION};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("Identity read returned wrong fields.");

  property p_id_fixed_bits;
    s_id_read |=> XFER_RDATA[23:20] == 4'h0
      && XFER_RDATA[19:16] == ARCH_VER;
  endproperty
  a_id_fixed_bits: assert property (p_id_fixed_bits)
    else $error("Identity fixed format bits are not zero.");

  property p_sc_roundtrip;
    s_sc_write ##1 (XFER_REQ.valid && !XFER_REQ.write
      && XFER_REQ.sel == `SEL_STATCTL && !CMP_VALID && EXC_SET == 6'h00)
      |=> XFER_ACK && !XFER_UNDEF && XFER_RDATA == $past(XFER_REQ.wdata, 2);
  endproperty
  a_sc_roundtrip: assert property (p_sc_roundtrip)
    else $error("Status/control did not read back the written word.");

  property p_cmp_lt;
    CMP_VALID && CMP_RES == CMP_LT |=> s_r.ctrl[31:28] == 4'h8;
  endproperty
  a_cmp_lt: assert property (p_cmp_lt)
    else $error("Less-than did not give flags 1000.");

  property p_cmp_eq;
    CMP_VALID && CMP_RES == CMP_EQ |=> s_r.ctrl[31:28] == 4'h6;
  endproperty
  a_cmp_eq: assert property (p_cmp_eq)
    else $error("Equal did not give flags 0110.");

  property p_cmp_carry;
    CMP_VALID && CMP_RES != CMP_LT |=> s_r.ctrl[29] && !s_r.ctrl[31];
  endproperty
  a_cmp_carry: assert property (p_cmp_carry)
    else $error("Carry flag wrong after comparison.");

  property p_cmp_ovf;
    CMP_VALID |=> s_r.ctrl[28] == ($past(CMP_RES) == CMP_UN);
  endproperty
  a_cmp_ovf: assert property (p_cmp_ovf)
    else $error("Overflow flag not tied to unordered result.");

  property p_modes;
    s_sc_write |=> DEFAULT_NAN_ENABLE == $past(XFER_REQ.wdata[25])
      && FLUSH_ZERO_ENABLE == $past(XFER_REQ.wdata[24]);
  endproperty
  a_modes: assert property (p_modes)
    else $error("Mode enables do not follow the written bits.");

  property p_round;
    s_sc_write |=> ROUND_MODE == round_e'($past(XFER_REQ.wdata[23:22]));
  endproperty
  a_round: assert property (p_round)
    else $error("Rounding mode does not follow the written field.");

  property p_vector;
    VECTOR_ITERATIONS == {1'b0, s_r.ctrl[18:16]} + 4'h1
      && VECTOR_STRIDE_INC == ((s_r.ctrl[21:20] == 2'h3) ? 2'h2 : 2'h1);
  endproperty
  a_vector: assert property (p_vector)
    else $error("Vector controls disagree with the length and stride.");

  property p_traps;
    s_sc_write |=> TRAP_EN == {$past(XFER_REQ.wdata[15]),
                               $past(XFER_REQ.wdata[12:8])};
  endproperty
  a_traps: assert property (p_traps)
    else $error("Trap enables do not follow the written bits.");

  property p_sticky_set;
    EXC_SET != 6'h00 |=> (sticky_of(s_r.ctrl) & $past(EXC_SET))
      == $past(EXC_SET);
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("Exception event did not set its sticky flag.");

  property p_sticky_hold;
    !(XFER_REQ.valid && XFER_REQ.write && XFER_REQ.sel == `SEL_STATCTL)
      |=> (sticky_of(s_r.ctrl) & sticky_of($past(s_r.ctrl)))
      == sticky_of($past(s_r.ctrl));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("Sticky flag cleared without a software write.");

  property p_undef;
    XFER_REQ.valid && XFER_REQ.sel != `SEL_IDENT
      && XFER_REQ.sel != `SEL_STATCTL |=> XFER_ACK && XFER_UNDEF;
  endproperty
  a_undef: assert property (p_undef)
    else $error("Unmapped transfer not flagged.");

endmodule : fp_status_and_id_regs

// ---- tb/fp_host_model.sv ----
`timescale 1ns/1ps

module fp_host_model
  import fp_regs_pkg::*;
(
  input  wire logic        CLOCK,
  output xfer_req_s        XFER_REQ,
  input  wire logic [31:0] XFER_RDATA,
  input  wire logic        XFER_ACK,
  input  wire logic        XFER_UNDEF
);
  // The request line idles low from time zero.
  initial begin
    XFER_REQ = '0;
  end

  // One transfer: the request stands one cycle, the answer one cycle later.
  // Released fields show the inverse so stale values are never trusted.
  task automatic xfer(input logic wr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic ack, output logic undef);
    @(posedge CLOCK);
    XFER_REQ <= '{valid: 1'b1, write: wr, sel: sel, wdata: wd};
    @(posedge CLOCK);
    XFER_REQ <= '{valid: 1'b0, write: ~wr, sel: ~sel, wdata: ~wd};
    #1;
    rd    = XFER_RDATA;
    ack   = XFER_ACK;
    undef = XFER_UNDEF;
  endtask : xfer
endmodule : fp_host_model

// ---- tb/fp_status_and_id_regs_test.sv ----
`timescale 1ns/1ps

module fp_status_and_id_regs_test
  import fp_regs_pkg::*;
;
  localparam logic [31:0] ID = 32'hC3056E97; // Arbitrary value.
  logic        clock, rst_b, cmp_valid, ack, undef;
  logic [5:0]  exc_set, trap_en;
  logic [31:0] rdata, rd;
  logic [3:0]  iters;
  logic [1:0]  stride;
  logic        nan_en, flush_en;
  cmp_e        cmp_res;
  round_e      round_mode;
  xfer_req_s   req;
  int          num_errors = 0;
  int          n_checks = 0;

  fp_status_and_id_regs #(.IMPLEMENTER(ID[31:24]), .ARCH_VER(ID[19:16]),
    .PART_NUM(ID[15:8]), .VARIANT(ID[7:4]), .REVISION(ID[3:0])) uut (
    .CLOCK(clock), .RST_B(rst_b), .XFER_REQ(req), .CMP_VALID(cmp_valid),
    .CMP_RES(cmp_res), .EXC_SET(exc_set), .XFER_RDATA(rdata),
    .XFER_ACK(ack), .XFER_UNDEF(undef), .DEFAULT_NAN_ENABLE(nan_en),
    .FLUSH_ZERO_ENABLE(flush_en), .ROUND_MODE(round_mode),
    .VECTOR_ITERATIONS(iters), .VECTOR_STRIDE_INC(stride),
    .TRAP_EN(trap_en));

  fp_host_model host (.CLOCK(clock), .XFER_REQ(req), .XFER_RDATA(rdata),
    .XFER_ACK(ack), .XFER_UNDEF(undef));

  // Clock at 50 MHz.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Transfer, then judge the handshake and, for a read, the returned word.
  task automatic go(input logic wr, input logic [3:0] sel,
                    input logic [31:0] wd, input logic [31:0] exp,
                    input logic exp_undef);
    logic a, u;
    host.xfer(wr, sel, wd, rd, a, u);
    chk("ack", 32'h1, {31'h0, a});
    chk("undef", {31'h0, exp_undef}, {31'h0, u});
    if (!wr) chk("rdata", exp, rd);
  endtask : go

  function automatic logic [31:0] modes();
    return {16'h0, nan_en, flush_en, round_mode, iters, stride, trap_en};
  endfunction : modes

  task automatic t_reset();
    chk("modes", {16'h0, 10'h005, 6'h00}, modes());
    go(1'b0, 4'h1, 32'h0, 32'h0, 1'b0);
  endtask : t_reset

  task automatic t_ident();
    go(1'b0, 4'h0, 32'h0, ID, 1'b0);
    go(1'b1, 4'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    go(1'b0, 4'h0, 32'h0, ID, 1'b0);
    go(1'b1, 4'hF, 32'h0, 32'h0, 1'b1);
    go(1'b0, 4'hF, 32'h0, 32'h0, 1'b1);
  endtask : t_ident

  task automatic t_modes();
    logic [31:0] w;
    for (int m = 0; m < 4; m++) begin
      w = 32'h03379F00 | (32'(m) << 22);
      go(1'b1, 4'h1, w, 32'h0, 1'b0);
      chk("modes", {16'h0, 2'h3, m[1:0], 4'h8, 2'h2, 6'h3F}, modes());
      go(1'b0, 4'h1, 32'h0, w, 1'b0);
    end
    go(1'b1, 4'h1, 32'h00210000, 32'h0, 1'b0);
    chk("modes", {16'h0, 10'h009, 6'h00}, modes());
  endtask : t_modes

  task automatic t_compare();
    cmp_e c [4] = '{CMP_LT, CMP_EQ, CMP_GT, CMP_UN};
    logic [3:0] e [4] = '{4'h8, 4'h6, 4'h2, 4'h3};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      cmp_valid <= 1'b1;
      cmp_res   <= c[i];
      @(posedge clock);
      cmp_valid <= 1'b0;
      go(1'b0, 4'h1, 32'h0, {e[i], 28'h0210000}, 1'b0);
    end
  endtask : t_compare

  // Raise event sets in turn, the last with four events at once, then clear by read-modify-write.
  task automatic t_sticky();
    logic [5:0] ev [3] = '{6'h20, 6'h01, 6'h1E};
    logic [31:0] acc;
    acc = 32'h30210000;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      exc_set <= ev[i];
      @(posedge clock);
      exc_set <= 6'h00;
      acc = acc | {24'h0, ev[i][5], 2'h0, ev[i][4:0]};
      go(1'b0, 4'h1, 32'h0, acc, 1'b0);
    end
    go(1'b0, 4'h1, 32'h0, acc, 1'b0);
    go(1'b1, 4'h1, rd & 32'hFFFFFF60, 32'h0, 1'b0);
    go(1'b0, 4'h1, 32'h0, 32'h30210000, 1'b0);
  endtask : t_sticky

  // A clearing write, an event and a compare in one cycle: hardware wins.
  task automatic t_collide();
    fork
      go(1'b1, 4'h1, 32'h0, 32'h0, 1'b0);
      begin
        @(posedge clock);
        exc_set   <= 6'h04;
        cmp_valid <= 1'b1;
        cmp_res   <= CMP_GT;
        @(posedge clock);
        exc_set   <= 6'h00;
        cmp_valid <= 1'b0;
      end
    join
    chk("modes", {16'h0, 10'h005, 6'h00}, modes());
    go(1'b0, 4'h1, 32'h0, 32'h20000004, 1'b0);
  endtask : t_collide

  // A reset in mid-run brings every field back to its reset value.
  task automatic t_midreset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
  endtask : t_midreset

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // Main sequence after a 16-cycle reset.
  initial begin
    rst_b     = 1'b0;
    cmp_valid = 1'b0;
    cmp_res   = CMP_LT;
    exc_set   = 6'h00;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_ident();
    t_modes();
    t_compare();
    t_sticky();
    t_collide();
    t_midreset();
    print_verdict();
  end

  // Watchdog cuts a hang short well beyond the expected run.
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule : fp_status_and_id_regs_test
